// ---- hdl/acc_top.v ----
// Behaviour
// R1 - read at fast offset starts conversion of current input and gain
// R2 - fast conversion done in 6.6 us, then result readable
// R3 - fast conversion leaves mux configuration and gain untouched
// R4 - second read of same offset returns result, mux unchanged
// R5 - common-mode read feeds one mux output to both amp inputs
// R6 - common-mode conversion takes about 13.2 us
// R7 - cross-connect read swaps mux outputs then converts
// R8 - cross-connect takes 13.2 us, gain and mux kept
// R9 - channel 7 of each mux selects an embedded test voltage
// R10 - mux config bit D4 routes test reference to negative input
// R11 - periodic interrupts start each loop at about 10 kHz
// R12 - loop 0 interrupt leads loop 1 by 36.6 us
// R13 - pulse-width calculation takes about 22 us
// R14 - each interrupt takes a gain-2 differential conversion, input 3 or 2
// R15 - each loop interrupt samples the opposite loop's variables
// R16 - host issues general conversions only in gap after loop 1
// R17 - iteration counter cleared at cycle start, incremented per interrupt
// R18 - counter holds 6 when serial communications finish
// R19 - host restores default settings before next interrupt conversion
// R20 - new request during conversion overrides and restarts converter
// R21 - only D7-D4 of a mux configuration write matter
// R22 - trigger read returns last result while launching new conversion
`timescale 1ns/1ps
`include "acc_consts.vh"
module acc_top
(
    input  wire        i_clk_sys,
    input  wire        i_reset_n,
    input  wire        i_cyc_start,
    input  wire        i_rd,
    input  wire        i_wr,
    input  wire [3:0]  i_addr,
    input  wire [15:0] i_wdata,
    input  wire [15:0] i_pos_mux_v,
    input  wire [15:0] i_neg_mux_v,
    input  wire [15:0] i_test_pos_v,
    input  wire [15:0] i_test_neg_v,
    input  wire [15:0] i_test_ref_v,
    output reg  [15:0] o_rdata,
    output reg         o_busy,
    output reg         o_done,
    output reg  [2:0]  o_chan,
    output reg  [2:0]  o_gain,
    output reg  [3:0]  o_mux_cfg,
    output reg  [1:0]  o_kind,
    output reg         o_loop0_irq,
    output reg         o_loop1_irq,
    output reg  [7:0]  o_iter_cnt
);
    // decode of a trigger offset into a conversion kind
    function [2:0] trig_decode;
        input [3:0] a;
        begin
            case (a)
                `ACC_OFS_FAST:  trig_decode = {1'b1, `ACC_KIND_NORM};
                `ACC_OFS_SWAP:  trig_decode = {1'b1, `ACC_KIND_SWAP};
                `ACC_OFS_NEGATIVE_COMMON_MODE_CONVERT: trig_decode = {1'b1, `ACC_KIND_NEGATIVE_COMMON_MODE_CONVERT};
                `ACC_OFS_POSITIVE_COMMON_MODE_CONVERT: trig_decode = {1'b1, `ACC_KIND_POSITIVE_COMMON_MODE_CONVERT};
                default:        trig_decode = 3'h0;
            endcase
        end
    endfunction

    // synchronise the external cycle-start strobe
    reg        cyc_s1_ff;
    reg        cyc_s2_ff;
    reg        cyc_s3_ff;
    wire       cyc_rise = cyc_s2_ff & ~cyc_s3_ff;
    always @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            cyc_s1_ff <= 1'b0;
            cyc_s2_ff <= 1'b0;
            cyc_s3_ff <= 1'b0;
        end
        else
        begin
            cyc_s1_ff <= i_cyc_start;
            cyc_s2_ff <= cyc_s1_ff;
            cyc_s3_ff <= cyc_s2_ff;
        end
    end

    // bus request decode
    wire [2:0] trig    = trig_decode(i_addr);
    wire       host_go = i_rd & trig[2];
    // channel select: addresses 3..7 (bit 3 clear, above the mux offset) are input reads
    wire       chan_rd = i_rd & ~i_addr[3] & (i_addr > `ACC_OFS_MUXCFG);

    // loop scheduler: 10 kHz period, loop 1 36.6 us after loop 0
    localparam [31:0] SEP_PH  = `ACC_LOOP_SEP_CYC;
    localparam [31:0] LAST_PH = `ACC_PERIOD_CYC - 1;
    reg [13:0] ph_ff;
    reg        pend_ff;    // which loop runs next: 0 or 1
    wire       hit0 = (ph_ff == 14'h0000);
    // spacing lets loop 0's 22 us calculation end before loop 1 starts
    wire       hit1 = (ph_ff == SEP_PH[13:0]);            // [R13]
    always @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            ph_ff       <= 14'h0001;
            pend_ff     <= 1'b0;
            o_loop0_irq <= 1'b0;
            o_loop1_irq <= 1'b0;
        end
        else
        begin
            // restart the frame on each communications cycle
            if (cyc_rise || ph_ff == LAST_PH[13:0])
                ph_ff <= 14'h0000;                          // [R11]
            else
                ph_ff <= ph_ff + 14'h0001;
            o_loop0_irq <= hit0 & ~cyc_rise;                // [R11]
            o_loop1_irq <= hit1 & ~cyc_rise;                // [R12]
            if (hit0)
                pend_ff <= 1'b1;
            else if (hit1)
                pend_ff <= 1'b0;
        end
    end

    // iteration counter: cleared at cycle start, +1 after each interrupt
    always @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
            o_iter_cnt <= 8'h00;
        else if (cyc_rise)
            o_iter_cnt <= 8'h00;                            // [R17]
        else if (o_loop0_irq | o_loop1_irq)
            o_iter_cnt <= o_iter_cnt + 8'h01;               // [R17] [R18]
    end

    // interrupt conversion: system settings, input of the opposite loop
    wire       irq_go   = o_loop0_irq | o_loop1_irq;
    wire [2:0] irq_chan = o_loop0_irq ? `ACC_SYS_CHAN_L0   // [R15]
                                      : `ACC_SYS_CHAN_L1;

    // mux, gain and channel state; only explicit writes, input reads, interrupts
    // or a cycle start change it, never a trigger read
    always @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_mux_cfg <= `ACC_RST_MUXCFG;
            o_gain    <= `ACC_RST_GAIN;
            o_chan    <= `ACC_RST_CHAN;
        end
        else if (cyc_rise)
        begin
            // defaults reloaded each communications cycle
            o_mux_cfg <= `ACC_RST_MUXCFG;
            o_gain    <= `ACC_SYS_GAIN;
            o_chan    <= `ACC_SYS_CHAN_L0;
        end
        else if (irq_go)
        begin
            o_gain <= `ACC_SYS_GAIN;                        // [R14]
            o_chan <= irq_chan;                             // [R14]
        end
        else if (i_wr && i_addr == `ACC_OFS_MUXCFG)
            o_mux_cfg <= i_wdata[`ACC_MUX_HI:`ACC_MUX_LO];  // [R21]
        else if (i_wr && i_addr == `ACC_OFS_GAIN)
            o_gain <= i_wdata[6:4];
        else if (chan_rd)
            o_chan <= i_addr[2:0];
    end

    // analog source select feeding the converter
    reg  [15:0] pos_in;
    reg  [15:0] neg_in;
    reg  [15:0] sample;
    reg  [1:0]  nxt_kind;
    always @*
    begin
        nxt_kind = irq_go ? `ACC_KIND_NORM : trig[1:0];
        // channel 7 picks the embedded test voltages
        pos_in = (o_chan == `ACC_TEST_CHAN) ? i_test_pos_v   // [R9]
                                            : i_pos_mux_v;
        neg_in = (o_chan == `ACC_TEST_CHAN) ? i_test_neg_v   // [R9]
                                            : i_neg_mux_v;
        if (o_mux_cfg[`ACC_MUX_TESTREF - `ACC_MUX_LO])
            neg_in = i_test_ref_v;                          // [R10]
        case (o_kind)
            `ACC_KIND_SWAP:  sample = neg_in - pos_in;      // [R7]
            `ACC_KIND_NEGATIVE_COMMON_MODE_CONVERT: sample = neg_in - neg_in;      // [R5]
            `ACC_KIND_POSITIVE_COMMON_MODE_CONVERT: sample = pos_in - pos_in;      // [R5]
            default:         sample = pos_in - neg_in;      // [R1]
        endcase
        // gain as a left shift; limitation: no saturation modelled
        sample = sample << o_gain;
    end

    // conversion start: host trigger, input read or interrupt
    wire conv_go = host_go | chan_rd | irq_go;              // [R20]
    wire slow    = ~irq_go & host_go &
                   (trig[1:0] != `ACC_KIND_NORM);           // [R6] [R8]
    always @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
            o_kind <= `ACC_KIND_NORM;
        else if (conv_go)
            o_kind <= nxt_kind;                             // [R3]
    end

    wire [15:0] res;
    wire        busy;
    wire        done;
    acc_conv_timer u_timer
    (
        .i_clk_sys (i_clk_sys),
        .i_reset_n (i_reset_n),
        .i_start   (conv_go),                               // [R20]
        .i_slow    (slow),                                  // [R2]
        .i_sample  (sample),
        .o_busy    (busy),
        .o_done    (done),
        .o_result  (res)
    );

    // status mirrors; one cycle late but straight from flip-flops
    always @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_busy <= 1'b0;
            o_done <= 1'b0;
        end
        else
        begin
            o_busy <= busy;
            o_done <= done;
        end
    end

    // read data: any trigger or input read returns the last result
    // while the new conversion launches; pend_ff reported at mux offset
    always @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
            o_rdata <= 16'h0000;
        else if (i_rd)
        begin
            if (host_go || chan_rd)
                o_rdata <= res;                             // [R22] [R4]
            else if (i_addr == `ACC_OFS_MUXCFG)
                o_rdata <= {8'h00, o_mux_cfg, 3'h0, pend_ff};
            else if (i_addr == `ACC_OFS_GAIN)
                o_rdata <= {9'h000, o_gain, 4'h0};
            else
                o_rdata <= 16'h0000;
        end
    end
endmodule // acc_top

// ---- pkg/acc_consts.vh ----
`ifndef ACC_CONSTS_VH
`define ACC_CONSTS_VH
// register offsets (word addresses on the processor port)
`define ACC_OFS_GAIN       4'h1
`define ACC_OFS_MUXCFG     4'h2
`define ACC_OFS_FAST       4'h8
`define ACC_OFS_SWAP       4'h9
`define ACC_OFS_NEGATIVE_COMMON_MODE_CONVERT      4'hA
`define ACC_OFS_POSITIVE_COMMON_MODE_CONVERT      4'hB
// mux configuration fields
`define ACC_MUX_TESTREF    4
`define ACC_MUX_HI         7
`define ACC_MUX_LO         4
// reset, interrupt, test channel and loop-count values
`define ACC_RST_MUXCFG     4'h0
`define ACC_RST_GAIN       3'h1
`define ACC_RST_CHAN       3'h3
`define ACC_SYS_GAIN       3'h1
`define ACC_SYS_CHAN_L0    3'h3
`define ACC_SYS_CHAN_L1    3'h2
`define ACC_TEST_CHAN      3'h7
`define ACC_LOOPS_AT_APP   8'h06
// times in ns and derived cycle counts at 10 ns
`define ACC_CLK_NS         10
`define ACC_FAST_NS        6600
`define ACC_SLOW_NS        13200
`define ACC_LOOP_SEP_NS    36600
`define ACC_PERIOD_NS      100000
`define ACC_FAST_CYC       (`ACC_FAST_NS / `ACC_CLK_NS)
`define ACC_SLOW_CYC       (`ACC_SLOW_NS / `ACC_CLK_NS)
`define ACC_LOOP_SEP_CYC   (`ACC_LOOP_SEP_NS / `ACC_CLK_NS)
`define ACC_PERIOD_CYC     (`ACC_PERIOD_NS / `ACC_CLK_NS)
// conversion kinds
`define ACC_KIND_NORM      2'h0
`define ACC_KIND_SWAP      2'h1
`define ACC_KIND_NEGATIVE_COMMON_MODE_CONVERT     2'h2
`define ACC_KIND_POSITIVE_COMMON_MODE_CONVERT     2'h3
`endif

// ---- hdl/acc_conv_timer.v ----
`timescale 1ns/1ps
`include "acc_consts.vh"
// conversion engine: restartable countdown that captures the sample at the end
module acc_conv_timer
(
    input  wire        i_clk_sys,
    input  wire        i_reset_n,
    input  wire        i_start,
    input  wire        i_slow,
    input  wire [15:0] i_sample,
    output reg         o_busy,
    output reg         o_done,
    output reg  [15:0] o_result
);
    reg [11:0] cnt_ff;

    // reload values kept 32 bits wide, cut to the counter on purpose
    localparam [31:0] FAST_LOAD = `ACC_FAST_CYC - 1;
    localparam [31:0] SLOW_LOAD = `ACC_SLOW_CYC - 1;

    // a new start simply reloads, so later requests override earlier ones
    always @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            cnt_ff   <= 12'h000;
            o_busy   <= 1'b0;
            o_done   <= 1'b0;
            o_result <= 16'h0000;
        end
        else
        begin
            o_done <= 1'b0;
            if (i_start)
            begin
                cnt_ff <= i_slow ? SLOW_LOAD[11:0]
                                 : FAST_LOAD[11:0];
                o_busy <= 1'b1;
            end
            else if (o_busy)
            begin
                if (cnt_ff == 12'h000)
                begin
                    o_busy   <= 1'b0;
                    o_done   <= 1'b1;
                    o_result <= i_sample;
                end
                else
                    cnt_ff <= cnt_ff - 12'h001;
            end
        end
    end
endmodule // acc_conv_timer

// ---- bench/acc_analog_src.sv ----
`timescale 1ns/1ps
// stand-in for the analog front end; fixed levels keep codes exact
module acc_analog_src
(
    output wire [15:0] o_pos_v,
    output wire [15:0] o_neg_v,
    output wire [15:0] o_tpos_v,
    output wire [15:0] o_tneg_v,
    output wire [15:0] o_tref_v
);
    // selected mux outputs, unequal so a swap flips the sign
    assign o_pos_v  = 16'h0100;
    assign o_neg_v  = 16'h0040;
    // channel 7 test levels and the internal reference
    assign o_tpos_v = 16'h0200;
    assign o_tneg_v = 16'h0080;
    assign o_tref_v = 16'h0020;
endmodule // acc_analog_src

// ---- bench/acc_checker.sv ----
`timescale 1ns/1ps
module acc_checker
(
    input wire        i_clk_sys,
    input wire        i_reset_n,
    input wire        i_cyc_start,
    input wire        i_rd,
    input wire        i_wr,
    input wire [3:0]  i_addr,
    input wire [15:0] i_wdata,
    input wire        o_busy,
    input wire        o_done,
    input wire [2:0]  o_chan,
    input wire [2:0]  o_gain,
    input wire [3:0]  o_mux_cfg,
    input wire [1:0]  o_kind,
    input wire        o_loop0_irq,
    input wire        o_loop1_irq,
    input wire [7:0]  o_iter_cnt
);
    reg [15:0] rd_age_ff;
    reg [15:0] l0_age_ff;
    reg [15:0] l1_age_ff;
    reg        slow_ff;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);
    // saturating ages; a cycle start voids the irq ages (phase restart)
    always @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            rd_age_ff <= 16'hFFFF;
            l0_age_ff <= 16'hFFFF;
            l1_age_ff <= 16'hFFFF;
            slow_ff   <= 1'b0;
        end
        else
        begin
            rd_age_ff <= i_rd ? 16'h0 : rd_age_ff + {15'h0, ~&rd_age_ff};
            l0_age_ff <= i_cyc_start ? 16'hFFFF : o_loop0_irq ? 16'h0 :
                         l0_age_ff + {15'h0, ~&l0_age_ff};
            l1_age_ff <= i_cyc_start ? 16'hFFFF : o_loop1_irq ? 16'h0 :
                         l1_age_ff + {15'h0, ~&l1_age_ff};
            if (i_rd)
                slow_ff <= (i_addr >= 4'h9) && (i_addr <= 4'hB);
        end
    end
    a_done_time: assert property (o_done && rd_age_ff < 16'd1400 |->
        rd_age_ff == (slow_ff ? 16'd1321 : 16'd661))
        else $error("conversion length wrong");
    a_done_idle: assert property (o_done |-> !o_busy)
        else $error("busy during done");
    a_loop_sep: assert property (o_loop1_irq && l0_age_ff < 16'd5000 |->
        l0_age_ff == 16'd3659) else $error("loop spacing wrong");
    a_loop_rate: assert property (o_loop0_irq && l1_age_ff < 16'd9000 |->
        l1_age_ff == 16'd6339) else $error("loop period wrong");
    a_irq_apart: assert property (!(o_loop0_irq && o_loop1_irq))
        else $error("both loops at once");
    a_cnt_step: assert property ($changed(o_iter_cnt) && o_iter_cnt != 8'h0
        |-> o_iter_cnt == $past(o_iter_cnt) + 8'h1) else $error("bad count");
    a_cal_keeps: assert property (i_rd && i_addr >= 4'h8 |=>
        $stable(o_chan) && $stable(o_gain) && $stable(o_mux_cfg))
        else $error("settings moved");
    a_kind_cal: assert property (i_rd && i_addr[3:2] == 2'h2 &&
        i_addr != 4'h8 |=> o_kind == $past(i_addr[1:0]))
        else $error("kind wrong");
    a_mux_nib: assert property (i_wr && i_addr == 4'h2 |=>
        o_mux_cfg == $past(i_wdata[7:4])) else $error("mux write wrong");
    a_fast_busy: assert property (i_rd && i_addr == 4'h8 |=> ##1 o_busy)
        else $error("fast read did not start");
    a_irq_chan: assert property (o_loop0_irq || o_loop1_irq |=>
        o_chan == ($past(o_loop0_irq) ? 3'h3 : 3'h2) && o_gain == 3'h1)
        else $error("irq settings wrong");
    c_fast: cover property (i_rd && i_addr == 4'h8);
    c_swap: cover property (i_rd && i_addr == 4'h9);
    c_loop: cover property (o_loop1_irq);
endmodule // acc_checker
bind acc_top acc_checker u_chk (.i_clk_sys, .i_reset_n, .i_cyc_start,
    .i_rd, .i_wr, .i_addr, .i_wdata, .o_busy, .o_done, .o_chan, .o_gain,
    .o_mux_cfg, .o_kind, .o_loop0_irq, .o_loop1_irq, .o_iter_cnt);

// ---- bench/acc_top_tb_top.sv ----
`timescale 1ns/1ps
module acc_top_tb_top;
    reg         i_clk_sys = 0, i_reset_n = 0, i_cyc_start = 0;
    reg         i_rd = 0, i_wr = 0;
    reg  [3:0]  i_addr = 0, a;
    reg  [15:0] i_wdata = 0;
    wire [15:0] pv, nv, tp, tn, tr, o_rdata;
    wire        o_busy, o_done, l0, l1;
    wire [2:0]  o_chan, o_gain;
    wire [3:0]  o_mux_cfg;
    wire [1:0]  o_kind;
    wire [7:0]  o_iter_cnt;
    integer     n_fail = 0, total_checks = 0, n;
    always #5 i_clk_sys = ~i_clk_sys;
    acc_analog_src src (.o_pos_v(pv), .o_neg_v(nv), .o_tpos_v(tp),
        .o_tneg_v(tn), .o_tref_v(tr));
    acc_top uut (.i_clk_sys, .i_reset_n, .i_cyc_start, .i_rd, .i_wr,
        .i_addr, .i_wdata, .i_pos_mux_v(pv), .i_neg_mux_v(nv),
        .i_test_pos_v(tp), .i_test_neg_v(tn), .i_test_ref_v(tr), .o_rdata,
        .o_busy, .o_done, .o_chan, .o_gain, .o_mux_cfg, .o_kind,
        .o_loop0_irq(l0), .o_loop1_irq(l1), .o_iter_cnt);
    task print_verdict;
    begin
        $display("checks %0d fails %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    end
    endtask
    task cmp_val(input [63:0] nm, input [15:0] e, input [15:0] g);
    begin
        total_checks = total_checks + 1;
        if (g !== e)
        begin
            n_fail = n_fail + 1;
            $display("[FAIL] %0s exp %h got %h", nm, e, g);
        end
    end
    endtask
    // one-cycle strobes launched at the falling edge
    task acc(input w, input [3:0] ad, input [15:0] d);
    begin
        @(negedge i_clk_sys);
        {i_rd, i_wr, i_addr, i_wdata} = {~w, w, ad, d};
        @(negedge i_clk_sys);
        {i_rd, i_wr} = 2'b00;
    end
    endtask
    // bounded waits; running out ends the run as a failure
    task wait_sig(input integer lim, input sel);
    begin
        n = 0;
        while ((sel ? l1 : o_done) !== 1'b1 && n < lim)
        begin
            @(negedge i_clk_sys);
            n = n + 1;
        end
        if (n >= lim)
        begin
            n_fail = n_fail + 1;
            print_verdict;
        end
    end
    endtask
    // start in the long gap after loop 1, clear of irq traffic
    task sync;
    begin
        wait_sig(12000, 1);
        repeat (700) @(negedge i_clk_sys);
    end
    endtask
    task conv(input [3:0] ad, input [15:0] e, input [15:0] lat);
    begin
        acc(0, ad, 0);
        wait_sig(3000, 0);
        cmp_val("latency", lat, n[15:0]);
        acc(0, ad, 0);
        cmp_val("result", e, o_rdata);
    end
    endtask
    initial
    begin
        repeat (2) @(negedge i_clk_sys);
        i_reset_n = 1;
        cmp_val("gain", 16'h1, o_gain);
        cmp_val("chan", 16'h3, o_chan);
        cmp_val("count", 16'h0, o_iter_cnt);
        i_cyc_start = 1;
        repeat (3) @(negedge i_clk_sys);
        i_cyc_start = 0;
        n = 0;
        while (o_iter_cnt !== 8'h06 && n < 40000)
        begin
            @(negedge i_clk_sys);
            n = n + 1;
        end
        cmp_val("count", 16'h6, o_iter_cnt);
        if (n >= 40000)
            print_verdict;
        $display("test loop counter done");
        sync;
        acc(0, 4'h3, 0);
        wait_sig(3000, 0);
        conv(4'h8, 16'h0180, 16'h0295);
        cmp_val("chan", 16'h3, o_chan);
        acc(0, 4'h7, 0);
        wait_sig(3000, 0);
        conv(4'h8, 16'h0300, 16'h0295);
        $display("test fast and test voltage done");
        sync;
        cmp_val("chan", 16'h2, o_chan);
        conv(4'h9, 16'hFE80, 16'h0529);
        for (a = 4'hA; a <= 4'hB; a = a + 4'h1)
            conv(a, 16'h0000, 16'h0529);
        cmp_val("gain", 16'h1, o_gain);
        $display("test swap and common mode done");
        sync;
        acc(1, 4'h2, 16'h001F);
        cmp_val("mux", 16'h1, o_mux_cfg);
        acc(0, 4'h2, 0);
        cmp_val("mux_rd", 16'h0010, o_rdata);
        acc(0, 4'h3, 0);
        wait_sig(3000, 0);
        conv(4'h8, 16'h01C0, 16'h0295);
        wait_sig(3000, 0);
        acc(1, 4'h2, 16'h0000);
        acc(0, 4'h9, 0);
        cmp_val("previous", 16'h01C0, o_rdata);
        acc(0, 4'h8, 0);
        wait_sig(3000, 0);
        cmp_val("latency", 16'h0295, n[15:0]);
        acc(0, 4'h8, 0);
        cmp_val("result", 16'h0180, o_rdata);
        acc(1, 4'h1, 16'h0020);
        conv(4'h8, 16'h0300, 16'h0295);
        cmp_val("gain", 16'h2, o_gain);
        acc(1, 4'h1, 16'h0010);
        $display("test reference and override done");
        print_verdict;
    end
endmodule // acc_top_tb_top
